// ### common/rsc_regs.vh
`ifndef RSC_REGS_VH
`define RSC_REGS_VH
// Special function register addresses
`define RSC_ADDR_MONITOR_CTRL 8'hff
`define RSC_ADDR_RESET_SOURCE 8'hef
// Supply monitor control fields
`define RSC_MON_EN_BIT 7
`define RSC_MON_STAT_BIT 6
// Reset source register fields
`define RSC_SRC_PIN_BIT 0
`define RSC_SRC_POR_BIT 1
// Reset and release values
`define RSC_PORT_LATCH_RESET 8'hff
`define RSC_PC_RESET 16'h0000
`define RSC_BYTE_ZERO 8'h00
`define RSC_WDT_DIVIDE 4'hc
// Power-on release delay in nanoseconds, and clock period
`define RSC_POR_DELAY_NS 300000
`define RSC_CLK_PERIOD_NS 8
`endif

// ### verilog/rsc_sync.v
// Two-flop synchroniser with asynchronous assert and synchronous release
module rsc_sync (
  input wire clk,
  input wire arst_b,
  output reg q_b
);
  reg meta_reg;

  // First stage is read only by the second stage
  always @(posedge clk or negedge arst_b) begin
    if (!arst_b) begin
      meta_reg <= 1'b0;
      q_b <= 1'b0;
    end else begin
      meta_reg <= 1'b1;
      q_b <= meta_reg;
    end
  end
endmodule

// ### verilog/rsc_ctrl.v
`include "rsc_regs.vh"

// Summary of operation
// - Reset state halts core, clears registers, interrupts
// - Data memory untouched by reset
// - Port latches all ones, weak pullups enabled
// - Drive reset pin low for supply resets
// - Release clears PC, selects internal oscillator
// - Release enables watchdog at clock over twelve
// - Fetch starts at address zero after reset
// - Hold power-on reset for release delay
// - Supply resets set power-on flag
// - Other resets clear power-on flag
// - Power-on reset or a control bit7 write enables supply monitor
// - Low supply holds reset and pin low
// - Monitor reset release has no delay
// - Monitor resets only when selected as source
// - Early selection may cause spurious reset
// - Control bit7 RW, bit6 RO, rest zero
// - Status bit shows live monitor output
// - Low reset pin enters reset state
// - Pin reset entry sets pin reset flag unless monitor trips same cycle
module rsc_ctrl #(
  parameter POR_DELAY_CYCLES = (`RSC_POR_DELAY_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS
) (
  input wire sys_clk,
  input wire rst_b,
  input wire supply_ok,
  input wire reset_pin_in,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  output reg reset_pin_out,
  output reg reset_pin_oe,
  output reg core_reset,
  output reg periph_reset,
  output reg [15:0] pc_start,
  output reg [7:0] port_latch,
  output reg weak_pullup_en,
  output reg osc_internal_sel,
  output reg wdt_enable,
  output reg [3:0] wdt_prescale,
  output reg irq_timer_en,
  output reg supply_monitor_enable_out
);
  localparam ST_POR = 3'b001;
  localparam ST_HOLD = 3'b010;
  localparam ST_RUN = 3'b100;
  localparam CW = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // Combine and synchronise the asynchronous reset requests
  wire rst_sync_b;
  reg supply_ok_reg;
  reg supply_ok_sync_reg;
  reg pin_meta_reg;
  reg pin_sync_reg;

  // Power-on reset release through two flops
  rsc_sync i_rel_sync (
    .clk(sys_clk),
    .arst_b(rst_b),
    .q_b(rst_sync_b)
  );

  // Synchronise monitor and pin levels so release is glitch free
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      supply_ok_reg <= 1'b0;
      supply_ok_sync_reg <= 1'b0;
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      supply_ok_reg <= supply_ok;
      supply_ok_sync_reg <= supply_ok_reg;
      pin_meta_reg <= reset_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and sequencer
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [CW-1:0] por_cnt_reg;
  reg mon_en_reg;
  reg mon_sel_reg;
  reg por_flag_reg;
  reg pin_flag_reg;
  reg [1:0] oe_hist_reg;
  wire mon_trip;
  wire pin_req;
  wire sel_mon_ctrl;
  wire sel_src;

  function is_addr;
    input [7:0] a;
    input [7:0] target;
    begin
      is_addr = (a == target);
    end
  endfunction

  assign sel_mon_ctrl = is_addr(sfr_addr, `RSC_ADDR_MONITOR_CTRL);
  assign sel_src = is_addr(sfr_addr, `RSC_ADDR_RESET_SOURCE);
  // Monitor trips only when both enabled and selected; selecting an unsettled monitor may trip it
  assign mon_trip = mon_en_reg && mon_sel_reg && !supply_ok_sync_reg;
  // Own pin drive echoes back through the sync flops, so it is masked until the echo has passed
  assign pin_req = !pin_sync_reg && !reset_pin_oe && !oe_hist_reg[0] && !oe_hist_reg[1];

  // History of our own pin drive, two cycles deep to match the synchroniser
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      oe_hist_reg <= 2'b11;
    end else begin
      oe_hist_reg <= {oe_hist_reg[0], reset_pin_oe};
    end
  end

  // Next-state logic
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_POR: begin
        if (por_cnt_reg == POR_DELAY_CYCLES[CW-1:0] - 1'b1) begin
          state_next = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (!mon_trip && !pin_req) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (mon_trip || pin_req) begin
          state_next = ST_HOLD;
        end
      end
      default: begin
        state_next = ST_POR;
      end
    endcase
  end

  // Sequencer, configuration and cause flags
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_reg <= ST_POR;
      por_cnt_reg <= {CW{1'b0}};
      mon_en_reg <= 1'b1;
      mon_sel_reg <= 1'b0;
      por_flag_reg <= 1'b1;
      pin_flag_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_POR) begin
        por_cnt_reg <= por_cnt_reg + 1'b1;
      end
      if (state_reg == ST_RUN && state_next == ST_HOLD) begin
        // Cause flags recorded at entry, visible on exit; monitor enable is kept
        por_flag_reg <= mon_trip;
        pin_flag_reg <= !mon_trip && pin_req;
      end else if (state_reg == ST_HOLD && state_next == ST_RUN) begin
        // Selection dropped on exit so a monitor hold lasts until the supply returns
        mon_sel_reg <= 1'b0;
      end else if (sfr_wr && sel_mon_ctrl && state_reg == ST_RUN) begin
        mon_en_reg <= sfr_wdata[`RSC_MON_EN_BIT];
      end else if (sfr_wr && sel_src && state_reg == ST_RUN) begin
        if (sfr_wdata[`RSC_SRC_POR_BIT]) begin
          mon_sel_reg <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sfr_rdata <= `RSC_BYTE_ZERO;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
      core_reset <= 1'b1;
      periph_reset <= 1'b1;
      pc_start <= `RSC_PC_RESET;
      port_latch <= `RSC_PORT_LATCH_RESET;
      weak_pullup_en <= 1'b1;
      osc_internal_sel <= 1'b1;
      wdt_enable <= 1'b0;
      wdt_prescale <= `RSC_WDT_DIVIDE;
      irq_timer_en <= 1'b0;
      supply_monitor_enable_out <= 1'b1;
    end else begin
      reset_pin_out <= 1'b0;
      // Pin driven low only for supply resets, never for pin resets
      reset_pin_oe <= (state_next == ST_POR) || (state_next == ST_HOLD && mon_trip);
      // Core halts and registers reload; data memory has no reset here
      core_reset <= (state_next != ST_RUN);
      periph_reset <= (state_next != ST_RUN);
      if (state_next != ST_RUN) begin
        port_latch <= `RSC_PORT_LATCH_RESET;
        pc_start <= `RSC_PC_RESET;
        osc_internal_sel <= 1'b1;
        irq_timer_en <= 1'b0;
        wdt_enable <= 1'b0;
      end else begin
        wdt_enable <= 1'b1;
        irq_timer_en <= 1'b1;
      end
      weak_pullup_en <= 1'b1;
      wdt_prescale <= `RSC_WDT_DIVIDE;
      supply_monitor_enable_out <= mon_en_reg;
      // Read data: live status, unused bits zero
      if (sfr_rd && sel_mon_ctrl) begin
        sfr_rdata <= {mon_en_reg, supply_ok_sync_reg, 6'b00_0000};
      end else if (sfr_rd && sel_src) begin
        sfr_rdata <= {6'b00_0000, por_flag_reg, pin_flag_reg};
      end else begin
        sfr_rdata <= `RSC_BYTE_ZERO;
      end
    end
  end
endmodule

// ### verif/rsc_monitor.sv
module rsc_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic reset_pin_in,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_rdata,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic core_reset,
  input wire logic [15:0] pc_start,
  input wire logic [7:0] port_latch,
  input wire logic weak_pullup_en,
  input wire logic osc_internal_sel,
  input wire logic wdt_enable,
  input wire logic [3:0] wdt_prescale,
  input wire logic irq_timer_en,
  input wire logic supply_monitor_enable_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////
  // Named steps; pin low five cycles covers both sync flops and the state edge
  sequence s_rd_mon; sfr_rd && sfr_addr == 8'hff; endsequence
  sequence s_pin_low; !reset_pin_in [*5]; endsequence
  property p_ports; port_latch == 8'hff && weak_pullup_en && pc_start == 16'h0000; endproperty
  a_ports: assert property (p_ports) else $error("port or fetch default lost");
  property p_run; !core_reset |-> wdt_enable && wdt_prescale == 4'hc && osc_internal_sel; endproperty
  a_run: assert property (p_run) else $error("run defaults wrong");
  property p_halt; core_reset |-> !irq_timer_en; endproperty
  a_halt: assert property (p_halt) else $error("timer irq live in reset");
  property p_low; !reset_pin_out; endproperty
  a_low: assert property (p_low) else $error("pin driven high");
  property p_drive; reset_pin_oe && $past(reset_pin_oe) |-> core_reset; endproperty
  a_drive: assert property (p_drive) else $error("pin driven outside reset");
  property p_pin; s_pin_low |-> core_reset; endproperty
  a_pin: assert property (p_pin) else $error("pin low without reset");
  property p_rd; s_rd_mon |=> sfr_rdata[5:0] == 6'h00 && sfr_rdata[7] == supply_monitor_enable_out; endproperty
  a_rd: assert property (p_rd) else $error("monitor control read wrong");
  property p_unm; sfr_rd && sfr_addr != 8'hff && sfr_addr != 8'hef |=> sfr_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule

// ### verif/rsc_pin_model.sv
module rsc_pin_model (
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic ext_low,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wired pin with pull-up; either party may pull it low
  assign pin = ((pin_oe && !pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule

// ### verif/reset_source_controller_bench.sv
module reset_source_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst_b = 0, supply_ok = 1, ext_low = 0, sfr_wr = 0, sfr_rd = 0, pin, pin_oe, pin_out, core_reset;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
  integer errors = 0, checks = 0, seed = 32'h7a85, cnt, mon_en, por_f, pin_f;
  // Short release delay keeps the run brief
  rsc_ctrl #(.POR_DELAY_CYCLES(20)) i_dut (.sys_clk, .rst_b, .supply_ok, .reset_pin_in(pin), .sfr_wr, .sfr_rd,
    .sfr_addr, .sfr_wdata, .sfr_rdata, .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .core_reset,
    .periph_reset(), .pc_start(), .port_latch(), .weak_pullup_en(), .osc_internal_sel(), .wdt_enable(),
    .wdt_prescale(), .irq_timer_en(), .supply_monitor_enable_out());
  rsc_pin_model i_pin (.pin_oe, .pin_out, .ext_low, .pin);
  always #4 sys_clk = ~sys_clk;
  //////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One strobe edge; read data is taken the cycle after
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] w);
    @(posedge sys_clk);
    sfr_wr <= wr;
    sfr_rd <= !wr;
    sfr_addr <= a;
    sfr_wdata <= w;
    @(posedge sys_clk);
    sfr_wr <= 0;
    sfr_rd <= 0;
    #1 d = sfr_rdata;
  endtask
  // Flag pin is masked while the power flag is set, since it is then undefined
  task automatic rd_regs;
    acc(0, 8'hef, 8'h00);
    chk({d[1], d[0] & ~d[1]}, {por_f[0], pin_f[0]});
    acc(0, 8'hff, 8'h00);
    chk(d, {mon_en[0], supply_ok, 6'h00});
  endtask
  // Bounded wait on the reset output, counting cycles
  task automatic wait_rst(input logic v);
    cnt = 0;
    while (core_reset !== v) begin
      @(posedge sys_clk);
      cnt++;
      if (cnt > 300) begin
        errors++;
        end_sim;
      end
    end
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1;
    @(posedge sys_clk);
    #1 chk(pin_oe, 1);
    wait_rst(0);
    chk(cnt >= 20, 1);
    mon_en = 1;
    por_f = 1;
    pin_f = 0;
    rd_regs;
    acc(0, ($random(seed) & 8'h0f) | 8'h10, 8'h00);
    chk(d, 8'h00);
    acc(1, 8'hff, $random(seed) & 8'h7f);
    mon_en = 0;
    @(posedge sys_clk) supply_ok <= 0;
    repeat (8) @(posedge sys_clk);
    #1 chk(core_reset, 0);
    rd_regs;
    @(posedge sys_clk) supply_ok <= 1;
    repeat (6) @(posedge sys_clk) ext_low <= 1;
    #1 chk({core_reset, pin_oe}, 2'b10);
    @(posedge sys_clk) ext_low <= 0;
    wait_rst(0);
    por_f = 0;
    pin_f = 1;
    rd_regs;
    acc(1, 8'hff, 8'h80);
    acc(1, 8'hef, 8'h02);
    mon_en = 1;
    @(posedge sys_clk) supply_ok <= 0;
    repeat (6) @(posedge sys_clk);
    #1 chk({core_reset, pin_oe}, 2'b11);
    @(posedge sys_clk) supply_ok <= 1;
    wait_rst(0);
    chk(cnt < 20, 1);
    por_f = 1;
    pin_f = 0;
    rd_regs;
    end_sim;
  end
endmodule
bind rsc_ctrl rsc_monitor i_mon (.sys_clk, .rst_b, .reset_pin_in, .sfr_rd, .sfr_addr, .sfr_rdata, .reset_pin_out,
  .reset_pin_oe, .core_reset, .pc_start, .port_latch, .weak_pullup_en, .osc_internal_sel, .wdt_enable,
  .wdt_prescale, .irq_timer_en, .supply_monitor_enable_out);
